// ---- ext_source.sv ----
// External gate and reset source that drives the timer's hardware input
`default_nettype none
module ext_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    input wire logic kick,
    output logic extSig
);
    logic extSig_q;
    // Level gates or holds the count, a one-cycle kick gives a rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            extSig_q <= 1'b0;
        end else begin
            extSig_q <= level | kick;
        end
    end
    assign extSig = extSig_q;
endmodule : ext_source
`default_nettype wire

// ---- period_timer.sv ----
// Register-mapped 8-bit period timer with prescaler, postscaler, modes
`default_nettype none
module period_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic extSig,
    output logic postscaledPulse,
    output logic irq
);
    logic [7:0] countQ, countD;
    logic [7:0] periodQ, periodD;
    logic [7:0] bufQ, bufD;
    logic runQ, runD;
    logic [timer_pkg::PSEL_W-1:0] pselQ, pselD;
    logic [timer_pkg::POST_W-1:0] postSelQ, postSelD;
    timer_pkg::mode_e modeQ, modeD;
    logic [timer_pkg::PRE_W-1:0] preQ, preD;
    logic [timer_pkg::POST_W-1:0] postQ, postD;
    logic extPrevQ;
    logic stoppedQ, stoppedD;
    logic [timer_pkg::EVT_W-1:0] statusQ, statusD;
    logic [timer_pkg::EVT_W-1:0] enableQ, enableD;
    logic [7:0] rdataQ, rdataD;
    logic pulseQ, pulseD;
    logic irqQ, irqD;

    // Address decode
    wire wrCount = wr && addr == timer_pkg::ADDR_COUNT;
    wire wrPeriod = wr && addr == timer_pkg::ADDR_PERIOD;
    wire wrCtrl = wr && addr == timer_pkg::ADDR_CTRL;
    wire wrCtrl1 = wr && addr == timer_pkg::ADDR_CTRL1;
    wire wrClear = wr && addr == timer_pkg::ADDR_CLEAR;
    wire wrEnable = wr && addr == timer_pkg::ADDR_ENABLE;
    wire wrAnyCtrl = wrCtrl || wrCtrl1;

    // Mode decode
    wire isHwGate = modeQ == timer_pkg::MODE_HW_GATE;
    wire isResetEdge = modeQ == timer_pkg::MODE_RESET_EDGE;
    wire isResetLevel = modeQ == timer_pkg::MODE_RESET_LEVEL;
    wire isOneShot = modeQ == timer_pkg::MODE_ONE_SHOT;
    wire isMono = modeQ == timer_pkg::MODE_MONOSTABLE;

    // External reset event, level or rising edge by mode
    wire extRise = extSig && !extPrevQ;
    wire extReset = (isResetLevel && extSig)
        || ((isResetEdge || isMono) && extRise);
    wire clrScalers = wrCount || wrAnyCtrl || extReset;

    // Counting enable: run bit, optional gate, monostable stop
    wire gateOk = !isHwGate || extSig;
    wire countEn = runQ && gateOk && !stoppedQ;

    // Prescaler rolls over at 2^psel - 1
    wire [7:0] preLimitW = (8'h01 << pselQ) - 8'h01;
    wire [timer_pkg::PRE_W-1:0] preLimit = preLimitW[timer_pkg::PRE_W-1:0];
    wire tick = countEn && preQ == preLimit && !clrScalers;

    // Match against the hidden buffer, not the visible period
    wire match = countQ == bufQ;
    wire periodEvt = tick && match;
    wire postHit = postQ >= postSelQ;

    // A control write suppresses the tick so the count stays put
    assign countD = wrCount ? wdata :
        extReset ? timer_pkg::COUNT_RST :
        periodEvt ? timer_pkg::COUNT_RST :
        tick ? countQ + 8'h01 : countQ;

    assign periodD = wrPeriod ? wdata : periodQ;

    assign bufD = (clrScalers || periodEvt) ? periodQ : bufQ;

    // Software write wins over the one-shot self-clear
    assign runD = wrCtrl ? wdata[timer_pkg::RUN_BIT] :
        (periodEvt && isOneShot) ? 1'b0 : runQ;

    assign pselD = wrCtrl ?
        wdata[timer_pkg::PSEL_LSB +: timer_pkg::PSEL_W] : pselQ;
    assign postSelD = wrCtrl1 ? wdata[timer_pkg::POST_W-1:0] : postSelQ;

    // Unused mode codes fall back to software gate
    wire [2:0] modeW = wdata[timer_pkg::MODE_LSB +: 3];
    wire modeOk = modeW <= 3'(timer_pkg::MODE_MONOSTABLE);
    assign modeD = !wrCtrl1 ? modeQ :
        modeOk ? timer_pkg::mode_e'(modeW) : timer_pkg::MODE_SOFT_GATE;

    // Monostable parks after a match until an external restart or a control write
    assign stoppedD = (extReset || wrAnyCtrl) ? 1'b0 :
        (periodEvt && isMono) ? 1'b1 : stoppedQ;

    assign preD = clrScalers ? '0 :
        !countEn ? preQ :
        tick ? '0 : preQ + 1'b1;

    // Postscaler steps on each period event; select 0 gives 1:1
    assign postD = clrScalers ? '0 :
        !periodEvt ? postQ :
        postHit ? '0 : postQ + 1'b1;
    assign pulseD = periodEvt && postHit;

    // Sticky events; a new event beats a same-cycle clear
    wire [timer_pkg::EVT_W-1:0] events = {extReset, pulseD, periodEvt};
    wire [timer_pkg::EVT_W-1:0] clrMask =
        wrClear ? wdata[timer_pkg::EVT_W-1:0] : '0;
    assign statusD = (statusQ & ~clrMask) | events;
    assign enableD = wrEnable ? wdata[timer_pkg::EVT_W-1:0] : enableQ;
    assign irqD = |(statusD & enableD);

    // Read data; clear register reads as zero
    wire [7:0] ctrlRd = {runQ, pselQ, 4'h0};
    wire [7:0] ctrl1Rd = {3'(modeQ), postSelQ};
    wire [7:0] rdMux =
        addr == timer_pkg::ADDR_COUNT ? countQ :
        addr == timer_pkg::ADDR_PERIOD ? periodQ :
        addr == timer_pkg::ADDR_CTRL ? ctrlRd :
        addr == timer_pkg::ADDR_CTRL1 ? ctrl1Rd :
        addr == timer_pkg::ADDR_STATUS ? 8'(statusQ) :
        addr == timer_pkg::ADDR_ENABLE ? 8'(enableQ) : 8'h00;
    assign rdataD = rd ? rdMux : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            countQ <= timer_pkg::COUNT_RST;
            periodQ <= timer_pkg::PERIOD_RST;
            bufQ <= timer_pkg::PERIOD_RST;
            runQ <= 1'b0;
            pselQ <= '0;
            postSelQ <= '0;
            modeQ <= timer_pkg::MODE_SOFT_GATE;
            stoppedQ <= 1'b0;
        end else begin
            countQ <= countD;
            periodQ <= periodD;
            bufQ <= bufD;
            runQ <= runD;
            pselQ <= pselD;
            postSelQ <= postSelD;
            modeQ <= modeD;
            stoppedQ <= stoppedD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            preQ <= '0;
            postQ <= '0;
            pulseQ <= 1'b0;
            extPrevQ <= 1'b0;
        end else begin
            preQ <= preD;
            postQ <= postD;
            pulseQ <= pulseD;
            extPrevQ <= extSig;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            statusQ <= '0;
            enableQ <= '0;
            irqQ <= 1'b0;
            rdataQ <= 8'h00;
        end else begin
            statusQ <= statusD;
            enableQ <= enableD;
            irqQ <= irqD;
            rdataQ <= rdataD;
        end
    end

    assign rdata = rdataQ;
    assign postscaledPulse = pulseQ;
    assign irq = irqQ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_oneshot_match;
        isOneShot && periodEvt && !wrCtrl;
    endsequence

    sequence s_parked;
        !runQ [*2];
    endsequence

    a_reset_values:
    assert property ($fell(rst) |-> countQ == 8'h00 && periodQ == 8'hFF)
        else $error("count or period wrong after reset");

    a_match_wraps:
    assert property (periodEvt && !wrCount && !extReset
        |=> countQ == 8'h00 && $past(countQ) == $past(bufQ))
        else $error("count did not wrap after match");

    a_tick_steps:
    assert property (tick && !match && !wrCount && !extReset
        |=> countQ == $past(countQ) + 8'h01)
        else $error("count did not step on prescaler rollover");

    a_gate_holds:
    assert property (isHwGate && !extSig && !wrCount && !extReset
        |=> countQ == $past(countQ))
        else $error("count moved while gate closed");

    a_soft_holds:
    assert property (!runQ && !wrCount && !extReset && !wrAnyCtrl
        |=> $stable(countQ) && preQ == $past(preQ))
        else $error("count moved while run clear");

    a_ext_reset_clears:
    assert property (extReset && !wrCount
        |=> countQ == 8'h00 && preQ == '0 && postQ == '0)
        else $error("external reset did not clear the timer");

    a_buffer_loads:
    assert property (clrScalers |=> bufQ == $past(periodQ))
        else $error("period buffer not reloaded");

    a_ctrl_keeps_count:
    assert property (wrAnyCtrl && !wrCount && !extReset
        |=> $stable(countQ) && preQ == '0 && postQ == '0)
        else $error("control write disturbed the count");

    a_oneshot_stops:
    assert property (s_oneshot_match ##1 (!wr && !extReset)
        |-> s_parked)
        else $error("one-shot did not stop");

    a_mono_keeps_run:
    assert property (isMono && periodEvt && !wrCtrl
        |=> runQ && stoppedQ)
        else $error("monostable dropped run enable");

    a_pulse_cause:
    assert property (postscaledPulse
        |-> $past(periodEvt) && $past(postQ) >= $past(postSelQ))
        else $error("postscaled pulse without a cause");

    a_post_steps:
    assert property (periodEvt && !postHit
        |=> postQ == $past(postQ) + 1'b1)
        else $error("postscaler did not step on match");
endmodule : period_timer
`default_nettype wire

// ---- period_timer_modes_bench.sv ----
// Register-level bench for the period timer and its modes
`default_nettype none
module period_timer_modes_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, wr, rd, level, kick;
    logic [timer_pkg::ADDR_W-1:0] addr;
    logic [7:0] wdata, v;
    logic [7:0] rstVal [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    wire logic [7:0] rdata;
    wire logic extSig, postscaledPulse, irq;
    int num_errors = 0;
    int checked = 0;
    int k;

    period_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .extSig(extSig),
        .postscaledPulse(postscaledPulse), .irq(irq));
    ext_source far (.clk(clk), .rst(rst), .level(level), .kick(kick),
        .extSig(extSig));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask : check

    task tally_and_finish;
        $display("errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        check(v, exp);
    endtask : rd_chk

    // Reads a register into v without judging it
    task rd_get(input logic [2:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_get

    // Counts postscaled pulses seen over a fixed number of cycles
    task pulses(input int cyc);
        k = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (postscaledPulse === 1'b1) k++;
        end
    endtask : pulses

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        level = 1'b0;
        kick = 1'b0;
        addr = '0;
        wdata = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd_chk(a[2:0], rstVal[a]);
        wr_reg(timer_pkg::ADDR_COUNT, 8'h37);
        repeat (5) @(posedge clk);
        rd_chk(timer_pkg::ADDR_COUNT, 8'h37);
        wr_reg(timer_pkg::ADDR_CTRL, 8'h1F);
        rd_chk(timer_pkg::ADDR_COUNT, 8'h37);
        rd_chk(timer_pkg::ADDR_CTRL, 8'h10);
        for (int m = 0; m < 8; m++) begin
            wr_reg(timer_pkg::ADDR_CTRL1, {m[2:0], 5'h03});
            rd_chk(timer_pkg::ADDR_CTRL1, {m < 6 ? m[2:0] : 3'h0, 5'h03});
        end
        $display("register test done");
        // Pulse spacing is (select+1)*(period+1)*2^prescale clocks
        for (int p = 0; p < 2; p++) for (int s = 0; s < 2; s++) begin
            wr_reg(timer_pkg::ADDR_PERIOD, 8'h02 + 8'(p * 3));
            wr_reg(timer_pkg::ADDR_CTRL1, 8'(s * 3));
            // Start from zero so the first match is a full period away
            wr_reg(timer_pkg::ADDR_COUNT, 8'h00);
            wr_reg(timer_pkg::ADDR_CTRL, 8'h90);
            rd_chk(timer_pkg::ADDR_PERIOD, 8'h02 + 8'(p * 3));
            pulses(240);
            check(8'(k), 8'(240 / ((3 * s + 1) * (3 * p + 3) * 2)));
        end
        $display("free-running test done");
        wr_reg(timer_pkg::ADDR_CTRL, 8'h00);
        wr_reg(timer_pkg::ADDR_ENABLE, 8'h01);
        @(posedge clk);
        check({7'h0, irq}, 8'h01);
        wr_reg(timer_pkg::ADDR_ENABLE, 8'h00);
        @(posedge clk);
        check({7'h0, irq}, 8'h00);
        wr_reg(timer_pkg::ADDR_ENABLE, 8'h01);
        wr_reg(timer_pkg::ADDR_CLEAR, 8'h07);
        @(posedge clk);
        check({7'h0, irq}, 8'h00);
        rd_chk(timer_pkg::ADDR_STATUS, 8'h00);
        $display("interrupt test done");
        wr_reg(timer_pkg::ADDR_PERIOD, 8'h03);
        wr_reg(timer_pkg::ADDR_CTRL1, 8'h83);
        wr_reg(timer_pkg::ADDR_COUNT, 8'h00);
        wr_reg(timer_pkg::ADDR_CTRL, 8'h80);
        repeat (10) @(posedge clk);
        rd_chk(timer_pkg::ADDR_CTRL, 8'h00);
        rd_chk(timer_pkg::ADDR_COUNT, 8'h00);
        wr_reg(timer_pkg::ADDR_CTRL1, 8'hA0);
        wr_reg(timer_pkg::ADDR_CTRL, 8'h80);
        pulses(12);
        rd_chk(timer_pkg::ADDR_CTRL, 8'h80);
        pulses(12);
        check(8'(k), 8'h00);
        @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        pulses(12);
        check(8'(k), 8'h01);
        $display("one-shot and monostable test done");
        wr_reg(timer_pkg::ADDR_PERIOD, 8'hFF);
        wr_reg(timer_pkg::ADDR_CTRL1, 8'h20);
        wr_reg(timer_pkg::ADDR_COUNT, 8'h00);
        wr_reg(timer_pkg::ADDR_CTRL, 8'h80);
        repeat (5) @(posedge clk);
        rd_chk(timer_pkg::ADDR_COUNT, 8'h00);
        level <= 1'b1;
        repeat (5) @(posedge clk);
        level <= 1'b0;
        rd_get(timer_pkg::ADDR_COUNT);
        check({7'h0, v != 8'h00}, 8'h01);
        wr_reg(timer_pkg::ADDR_CTRL1, 8'h60);
        level <= 1'b1;
        wr_reg(timer_pkg::ADDR_COUNT, 8'h40);
        repeat (3) @(posedge clk);
        rd_chk(timer_pkg::ADDR_COUNT, 8'h00);
        level <= 1'b0;
        wr_reg(timer_pkg::ADDR_CTRL1, 8'h40);
        repeat (20) @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        rd_get(timer_pkg::ADDR_COUNT);
        check({7'h0, v < 8'h06}, 8'h01);
        rd_get(timer_pkg::ADDR_STATUS);
        check({7'h0, v[timer_pkg::EVT_EXTRST]}, 8'h01);
        $display("gate and reset test done");
        tally_and_finish();
    end

    initial begin
        #(4000 * 100);
        num_errors++;
        tally_and_finish();
    end
endmodule : period_timer_modes_bench
`default_nettype wire

// ---- timer_pkg.sv ----
// Constants and types for the 8-bit period timer
// Operation
// - Six modes: software gate, hardware gate, edge reset, level reset (all free-running), one-shot and monostable.
// - The count steps on each rollover of the programmable prescaler.
// - A count equal to the period buffer drives a one-clock event into the postscaler at the prescaler rollover.
// - After a match the count is cleared on the next timer clock.
// - In gate mode the external signal holds the count while low and lets it run while high.
// - In reset modes an external level or rising edge clears the count.
// - Software sees only the period value; the timer compares against a hidden period buffer.
// - The buffer reloads on a count write, a control write, a match with rollover, or an external reset.
// - The count is read/write; reset clears it and sets the period value to FFh.
// - Count write, control write, reset and external reset clear both scalers; a control write keeps the count.
// - In free-running mode a match reloads the count to 00h and steps the postscaler.
// - When the postscaler reaches the postscale select value a one-clock pulse is emitted and it clears.
// - In one-shot mode a match clears run enable and stops until software sets it again.
// - One-shot stops at the first period, so with a postscale select other than 0 no postscaled pulse is emitted.
// - In monostable mode run enable stays set on a match and an external reset event restarts the timer.
// - In software gate mode the count steps while run enable is set and holds while it is clear.
`default_nettype none
package timer_pkg;
    localparam int CNT_W = 8;
    localparam int POST_W = 5;
    localparam int PSEL_W = 3;
    localparam int PRE_W = 7;
    localparam int ADDR_W = 3;
    localparam int EVT_W = 3;

    localparam logic [2:0] ADDR_COUNT = 3'h0;
    localparam logic [2:0] ADDR_PERIOD = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_CTRL1 = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam logic [2:0] ADDR_CLEAR = 3'h5;
    localparam logic [2:0] ADDR_ENABLE = 3'h6;

    localparam int RUN_BIT = 7;
    localparam int PSEL_LSB = 4;
    localparam int MODE_LSB = 5;

    localparam int EVT_MATCH = 0;
    localparam int EVT_PULSE = 1;
    localparam int EVT_EXTRST = 2;

    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;

    typedef enum logic [2:0] {
        MODE_SOFT_GATE,
        MODE_HW_GATE,
        MODE_RESET_EDGE,
        MODE_RESET_LEVEL,
        MODE_ONE_SHOT,
        MODE_MONOSTABLE
    } mode_e;
endpackage : timer_pkg
`default_nettype wire
